// file: hdl/jk_elem.sv
`timescale 1ns/1ns
// one storage element, sampled on the system clock
module jk_elem #(
    parameter jk_pair_pkg::variant_t VARIANT = jk_pair_pkg::VARIANT_FALL_EDGE
) (
    input wire logic clock,
    input wire logic srst,
    jk_elem_if.elem port
);
    import jk_pair_pkg::*;

    logic clkPrev_ff;
    logic masterFirst_ff;
    logic masterSecond_ff;
    logic state_ff;
    logic fallEdge;
    logic asyncActive;
    logic applyFirst;
    logic applySecond;

    // next state from the data pair and the prior_state
    function automatic logic jk_next(input logic first, input logic second,
                                     input logic prior_state);
        unique case (jk_action_t'({first, second}))
            JK_HOLD: jk_next = prior_state;
            JK_CLEAR: jk_next = 1'b0;
            JK_SET: jk_next = 1'b1;
            JK_TOGGLE: jk_next = ~prior_state;
        endcase
    endfunction

    assign fallEdge = clkPrev_ff & ~port.elemClk;
    assign asyncActive = ~port.setLow | ~port.async_zero_low;

    // previous element clock level for edge detection
    always_ff @(posedge clock) begin
        if (srst) begin
            clkPrev_ff <= 1'b0;
        end else begin
            clkPrev_ff <= port.elemClk;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            masterFirst_ff <= 1'b0;
            masterSecond_ff <= 1'b0;
        end else if (port.elemClk) begin
            masterFirst_ff <= port.dataFirst;
            masterSecond_ff <= port.dataSecond;
        end
    end

    // data pair used at the falling edge depends on the variant
    assign applyFirst = (VARIANT == VARIANT_MASTER_SLAVE) ? masterFirst_ff : port.dataFirst;
    assign applySecond = (VARIANT == VARIANT_MASTER_SLAVE) ? masterSecond_ff : port.dataSecond;

    // storage: preset/clear override, else update on falling edge
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= STATE_RESET;
        end else if (asyncActive) begin
            state_ff <= port.async_zero_low;
        end else if (fallEdge) begin
            state_ff <= jk_next(applyFirst, applySecond, state_ff);
        end
    end

    // both asserted drives both high, not retained
    assign port.trueOut = (~port.setLow) ? 1'b1 : (~port.async_zero_low ? 1'b0 : state_ff);
    assign port.compOut = (~port.async_zero_low) ? 1'b1 : (~port.setLow ? 1'b0 : ~state_ff);
endmodule

// file: hdl/jk_elem_if.sv
`timescale 1ns/1ns
// signals of one storage element after synchronisation
interface jk_elem_if;
    logic elemClk;
    logic dataFirst;
    logic dataSecond;
    logic setLow;
    logic async_zero_low;
    logic trueOut;
    logic compOut;
    modport elem (
        input elemClk, dataFirst, dataSecond, setLow, async_zero_low,
        output trueOut, compOut
    );
    modport top (
        output elemClk, dataFirst, dataSecond, setLow, async_zero_low,
        input trueOut, compOut
    );
endinterface

// file: hdl/jk_pair.sv
`timescale 1ns/1ns
module jk_pair #(
    parameter jk_pair_pkg::variant_t VARIANT = jk_pair_pkg::VARIANT_FALL_EDGE
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [jk_pair_pkg::ELEMENT_COUNT-1:0] elemClk,
    input wire logic [jk_pair_pkg::ELEMENT_COUNT-1:0] dataFirst,
    input wire logic [jk_pair_pkg::ELEMENT_COUNT-1:0] dataSecond,
    input wire logic [jk_pair_pkg::ELEMENT_COUNT-1:0] setLow,
    input wire logic [jk_pair_pkg::ELEMENT_COUNT-1:0] async_zero_low,
    output logic [jk_pair_pkg::ELEMENT_COUNT-1:0] trueOut,
    output logic [jk_pair_pkg::ELEMENT_COUNT-1:0] compOut
);
    import jk_pair_pkg::*;

    // latency and ordering seen from the pins, in system clock edges:
    // a forcing pin reaches the outputs at the third edge that samples it
    // a falling element clock reaches the outputs at the fourth edge
    // elements never share a flop, so the two run independently
    // element clock high and low phases each need two system clocks or more
    // edge variant: data settled three clocks before the clock falls
    // master-slave variant: data held through the whole high phase
    // both forcing pins low, then released, leaves the cleared state
    // data pins change the stored state only at a falling element clock
    // the element clock is ignored while a forcing pin is low
    // reset loads the cleared state and idles every synchroniser
    // every pin passes two flops; only the second stage feeds logic
    // outputs come from flops, one edge behind the storage logic

    // element clock pin stages
    logic [ELEMENT_COUNT-1:0] clkMeta_ff;
    logic [ELEMENT_COUNT-1:0] clkSync_ff;

    // first data pin stages
    logic [ELEMENT_COUNT-1:0] firstMeta_ff;
    logic [ELEMENT_COUNT-1:0] firstSync_ff;

    // second data pin stages
    logic [ELEMENT_COUNT-1:0] secondMeta_ff;
    logic [ELEMENT_COUNT-1:0] secondSync_ff;

    // set pin stages, idle high
    logic [ELEMENT_COUNT-1:0] setMeta_ff;
    logic [ELEMENT_COUNT-1:0] setSync_ff;

    // clear pin stages, idle high
    logic [ELEMENT_COUNT-1:0] zeroMeta_ff;
    logic [ELEMENT_COUNT-1:0] zeroSync_ff;

    // storage results per element, before the output flops
    logic [ELEMENT_COUNT-1:0] elemTrue;
    logic [ELEMENT_COUNT-1:0] elemComp;

    // output flops
    logic [ELEMENT_COUNT-1:0] trueOut_ff;
    logic [ELEMENT_COUNT-1:0] compOut_ff;

    // one level copied onto every element
    function automatic logic [ELEMENT_COUNT-1:0] fill(input logic level);
        return {ELEMENT_COUNT{level}};
    endfunction

    // refuse settings that the element logic cannot serve
    if (ELEMENT_COUNT < 1) begin : g_bad_count
        $error("element count must be one or more");
    end

    if (!(VARIANT inside {VARIANT_MASTER_SLAVE, VARIANT_FALL_EDGE})) begin : g_bad_variant
        $error("unknown element variant");
    end

    // element clock pins, first stage
    always_ff @(posedge clock) begin
        if (srst) begin
            clkMeta_ff <= fill(PIN_LOW_IDLE);
        end else begin
            clkMeta_ff <= elemClk;
        end
    end

    // element clock pins, second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            clkSync_ff <= fill(PIN_LOW_IDLE);
        end else begin
            clkSync_ff <= clkMeta_ff;
        end
    end

    // first data pins, first stage
    always_ff @(posedge clock) begin
        if (srst) begin
            firstMeta_ff <= fill(PIN_LOW_IDLE);
        end else begin
            firstMeta_ff <= dataFirst;
        end
    end

    // first data pins, second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            firstSync_ff <= fill(PIN_LOW_IDLE);
        end else begin
            firstSync_ff <= firstMeta_ff;
        end
    end

    // second data pins, first stage
    always_ff @(posedge clock) begin
        if (srst) begin
            secondMeta_ff <= fill(PIN_LOW_IDLE);
        end else begin
            secondMeta_ff <= dataSecond;
        end
    end

    // second data pins, second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            secondSync_ff <= fill(PIN_LOW_IDLE);
        end else begin
            secondSync_ff <= secondMeta_ff;
        end
    end

    // set pins, first stage, reset to inactive
    always_ff @(posedge clock) begin
        if (srst) begin
            setMeta_ff <= fill(PIN_HIGH_IDLE);
        end else begin
            setMeta_ff <= setLow;
        end
    end

    // set pins, second stage, reset to inactive
    always_ff @(posedge clock) begin
        if (srst) begin
            setSync_ff <= fill(PIN_HIGH_IDLE);
        end else begin
            setSync_ff <= setMeta_ff;
        end
    end

    // clear pins, first stage, reset to inactive
    always_ff @(posedge clock) begin
        if (srst) begin
            zeroMeta_ff <= fill(PIN_HIGH_IDLE);
        end else begin
            zeroMeta_ff <= async_zero_low;
        end
    end

    // clear pins, second stage, reset to inactive
    always_ff @(posedge clock) begin
        if (srst) begin
            zeroSync_ff <= fill(PIN_HIGH_IDLE);
        end else begin
            zeroSync_ff <= zeroMeta_ff;
        end
    end

    // true outputs, cleared state during reset
    always_ff @(posedge clock) begin
        if (srst) begin
            trueOut_ff <= fill(STATE_RESET);
        end else begin
            trueOut_ff <= elemTrue;
        end
    end

    // complement outputs, cleared state during reset
    always_ff @(posedge clock) begin
        if (srst) begin
            compOut_ff <= fill(~STATE_RESET);
        end else begin
            compOut_ff <= elemComp;
        end
    end

    // drive the ports from the output flops
    assign trueOut = trueOut_ff;
    assign compOut = compOut_ff;

    for (genvar i = 0; i < ELEMENT_COUNT; i++) begin : g_elem
        // carrier between this top and the element
        jk_elem_if link();

        // synchronised clock and data pins of this element
        assign link.elemClk = clkSync_ff[i];
        assign link.dataFirst = firstSync_ff[i];
        assign link.dataSecond = secondSync_ff[i];

        // synchronised forcing pins of this element
        assign link.setLow = setSync_ff[i];
        assign link.async_zero_low = zeroSync_ff[i];

        // storage results back out of the carrier
        assign elemTrue[i] = link.trueOut;
        assign elemComp[i] = link.compOut;

        // storage logic of one element
        jk_elem #(
            .VARIANT(VARIANT)
        ) u_elem (
            .clock(clock),
            .srst(srst),
            .port(link.elem)
        );
    end
endmodule

// file: hdl/jk_pair_pkg.sv
package jk_pair_pkg;
    // number of independent storage elements
    localparam int ELEMENT_COUNT = 2;
    // storage value after the synchronous reset
    localparam logic STATE_RESET = 1'b0;
    // synchroniser reset level of the clock and data pins
    localparam logic PIN_LOW_IDLE = 1'h0;
    // synchroniser reset level of the active-low forcing pins
    localparam logic PIN_HIGH_IDLE = 1'h1;
    // variant selection codes
    typedef enum logic [0:0] {
        VARIANT_MASTER_SLAVE = 1'b0,
        VARIANT_FALL_EDGE = 1'b1
    } variant_t;
    // data input pair encodings (first, second)
    typedef enum logic [1:0] {
        JK_HOLD = 2'b00,
        JK_CLEAR = 2'b01,
        JK_SET = 2'b10,
        JK_TOGGLE = 2'b11
    } jk_action_t;
endpackage

// file: test/jk_drive_model.sv
`timescale 1ns/1ns
// surrounding logic: loads a data pair, then gives one clock pulse
module jk_drive_model (
    input wire logic clock,
    input wire logic go,
    input wire jk_pair_pkg::jk_action_t act,
    output logic pinClk = 1'b0,
    output logic [1:0] pair = 2'h0
);
    import jk_pair_pkg::*;
    logic [3:0] step = 4'h0;
    // data held before and through pulse
    always @(negedge clock) begin
        if (go) begin
            pair <= act;
            step <= 4'h8;
        end else if (step != 4'h0) begin
            step <= step - 4'h1;
        end
        pinClk <= (step > 4'h1) && (step < 4'h5);
    end
endmodule

// file: test/jk_pair_monitor.sv
`timescale 1ns/1ns
// watches element 0 of the pair at its ports
module jk_pair_monitor (
    input wire logic clock,
    input wire logic srst,
    input wire logic [1:0] elemClk,
    input wire logic [1:0] dataFirst,
    input wire logic [1:0] dataSecond,
    input wire logic [1:0] setLow,
    input wire logic [1:0] async_zero_low,
    input wire logic [1:0] trueOut,
    input wire logic [1:0] compOut
);
    import jk_pair_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic pinsOff = setLow[0] && async_zero_low[0];
    // a clean falling clock with a given data pair and no forcing pins
    sequence s_fall(act);
        pinsOff [*3] ##1 ($fell(elemClk[0]) && {dataFirst[0], dataSecond[0]} == act)
            ##0 pinsOff [*5];
    endsequence
    property p_set_pin; (!setLow[0] && async_zero_low[0]) [*4] |-> trueOut[0] && !compOut[0];
    endproperty
    property p_clear_pin; (setLow[0] && !async_zero_low[0]) [*4] |-> !trueOut[0] && compOut[0];
    endproperty
    property p_both_pins; (!setLow[0] && !async_zero_low[0]) [*4] |-> trueOut[0] && compOut[0];
    endproperty
    property p_complement; pinsOff [*4] |-> trueOut[0] != compOut[0]; endproperty
    property p_steady; (pinsOff && $stable(elemClk[0])) [*6] |-> $stable(trueOut[0]); endproperty
    property p_jk_set; s_fall(JK_SET) |-> trueOut[0]; endproperty
    property p_jk_clear; s_fall(JK_CLEAR) |-> !trueOut[0]; endproperty
    property p_jk_toggle; s_fall(JK_TOGGLE) |-> trueOut[0] != $past(trueOut[0], 4); endproperty
    a_set_pin: assert property (p_set_pin) else $error("set pin output wrong");
    a_clear_pin: assert property (p_clear_pin) else $error("clear pin output wrong");
    a_both_pins: assert property (p_both_pins) else $error("both pins output wrong");
    a_complement: assert property (p_complement) else $error("outputs not opposite");
    a_steady: assert property (p_steady) else $error("output moved on steady clock");
    a_jk_set: assert property (p_jk_set) else $error("set pair not loaded");
    a_jk_clear: assert property (p_jk_clear) else $error("clear pair not loaded");
    a_jk_toggle: assert property (p_jk_toggle) else $error("toggle pair wrong");
endmodule
bind jk_pair jk_pair_monitor i_mon (.clock, .srst, .elemClk, .dataFirst, .dataSecond, .setLow,
    .async_zero_low, .trueOut, .compOut);

// file: test/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin errCount++; \
    $display("[FAIL] %s expected %b seen %b", n, e, s); end end
module tb;
    import jk_pair_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [1:0] go = 2'h0, setLow = 2'h3, async_zero_low = 2'h3;
    logic [1:0] elemClk, dataFirst, dataSecond, trueOut, compOut, pairs [2];
    logic [1:0] trueOutMs, compOutMs;
    jk_action_t act [2] = '{JK_HOLD, JK_HOLD};
    int errCount = 0, numChecks = 0;
    always #2 clock = ~clock;
    jk_pair i_dut (.clock, .srst, .elemClk, .dataFirst, .dataSecond, .setLow, .async_zero_low,
        .trueOut, .compOut);
    // master-slave variant on the same pins
    jk_pair #(.VARIANT(VARIANT_MASTER_SLAVE)) i_dut_ms (.clock, .srst, .elemClk, .dataFirst,
        .dataSecond, .setLow, .async_zero_low, .trueOut(trueOutMs), .compOut(compOutMs));
    // one driving model for each element
    for (genvar g = 0; g < 2; g++) begin : g_drv
        jk_drive_model i_drv (.clock, .go(go[g]), .act(act[g]), .pinClk(elemClk[g]),
            .pair(pairs[g]));
        assign {dataFirst[g], dataSecond[g]} = pairs[g];
    end
    function automatic logic nxt(logic q, logic [1:0] a);
        return (a == 2'h0) ? q : (a == 2'h3) ? !q : a[1];
    endfunction
    task automatic idle(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic pulse(jk_action_t a0, jk_action_t a1);
        act[0] <= a0;
        act[1] <= a1;
        go <= 2'h3;
        idle(1);
        go <= 2'h0;
        idle(16);
    endtask
    // forcing pins: set, clear, both, release
    task automatic pin_case;
        logic [3:0] tbl [4] = '{4'h6, 4'h9, 4'h3, 4'hD};
        foreach (tbl[i]) begin
            setLow = {2{tbl[i][3]}};
            async_zero_low = {2{tbl[i][2]}};
            idle(5);
            `CHK("pin true", {2{tbl[i][1]}}, trueOut)
            `CHK("pin comp", {2{tbl[i][0]}}, compOut)
            `CHK("ms pin true", {2{tbl[i][1]}}, trueOutMs)
            `CHK("ms pin comp", {2{tbl[i][0]}}, compOutMs)
        end
    endtask
    // every data pair on both elements, in opposite orders
    task automatic jk_case;
        jk_action_t seq [5] = '{JK_SET, JK_HOLD, JK_TOGGLE, JK_TOGGLE, JK_CLEAR};
        logic [1:0] q = 2'h0;
        foreach (seq[i]) begin
            q = {nxt(q[1], seq[4 - i]), nxt(q[0], seq[i])};
            pulse(seq[i], seq[4 - i]);
            `CHK("jk true", q, trueOut)
            `CHK("jk comp", ~q, compOut)
            `CHK("ms jk true", q, trueOutMs)
            `CHK("ms jk comp", ~q, compOutMs)
        end
    endtask
    // pins held low keep the clock pulse out
    task automatic force_case;
        setLow = 2'h2;
        async_zero_low = 2'h1;
        pulse(JK_TOGGLE, JK_TOGGLE);
        `CHK("forced", 2'h1, trueOut)
        `CHK("forced comp", 2'h2, compOut)
        `CHK("ms forced", 2'h1, trueOutMs)
        setLow = 2'h3;
        async_zero_low = 2'h3;
        idle(5);
        `CHK("released", 2'h1, trueOut)
        `CHK("ms released", 2'h1, trueOutMs)
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        idle(4);
        srst = 1'b0;
        pin_case();
        jk_case();
        force_case();
        report_and_stop();
    end
    // watchdog well beyond the expected run
    initial begin
        #2000;
        errCount++;
        report_and_stop();
    end
endmodule
